// ===== logic/pm_cap_cfg.svh
// Purpose: Constants for the power-management capabilities register.
// Assumes: Included by bare name from the package and the register module.
// Notes: Field positions, values and timing counts live here; types live in the package.
//
// Behaviour
// - With second mode-select low, D0, D1, D2 and D3 are all supported.
// - With second mode-select high, supportedStates offers no power state; bits 10 and 9 still follow first mode-select.
// - Bits 15:11 wake-event support are read-only and always read zero.
// - Bit 10 reads 1 when first mode-select is 0, else 0.
// - Bit 9 reads 1 when first mode-select is 0, else 0.
// - Bits 8:6 carry a design-chosen auxiliary-supply current value.
// - Bit 5 special-initialization flag always reads zero.
// - Bit 4 is reserved and always reads zero.
// - Bit 3 wake-event clock flag always reads zero.
// - Bits 2:0 read 001b when first mode-select is 1.
// - Bits 2:0 read 010b when first mode-select is 0.
`ifndef PM_CAP_CFG_SVH
`define PM_CAP_CFG_SVH

`define PMC_OFFSET        8'hde
`define PMC_WAKE_MSB      15
`define PMC_WAKE_LSB      11
`define PMC_DEEPER_BIT    10
`define PMC_LIGHT_BIT     9
`define PMC_AUX_MSB       8
`define PMC_AUX_LSB       6
`define PMC_INIT_BIT      5
`define PMC_RSVD_BIT      4
`define PMC_WCLK_BIT      3
`define PMC_REV_MSB       2
`define PMC_REV_LSB       0

`define PMC_WAKE_NONE     5'h00
`define PMC_REV_1_0       3'h1
`define PMC_REV_1_1       3'h2
`define PMC_AUX_DEFAULT   3'h0
`define PMC_STATES_ALL    4'hf
`define PMC_STATES_NONE   4'h0
`define PMC_READ_ZERO     16'h0000
`define PMC_BYTES_ALL     2'h3

`define PMC_SETTLE_CYCLES 2'h2

`endif

// ===== logic/pm_cap_pkg.sv
// Purpose: Types shared by the power-management capabilities register files.
// Assumes: The constants header is on the include path.
// Notes: The capability struct is packed so its layout is the register layout.
`include "pm_cap_cfg.svh"

package pm_cap_pkg;

  // One configuration access as seen at the register port.
  typedef struct packed {
    logic       write;
    logic [7:0] addr;
    logic [1:0] byteEn;
  } cfg_req_s;

  // Field layout of the capabilities word, most significant field first.
  typedef struct packed {
    logic [4:0] wakeEventSupportField;
    logic       deeperStateSupportBit;
    logic       lightStateSupportBit;
    logic [2:0] auxCurrent;
    logic       specialInit;
    logic       reservedBit;
    logic       wakeEventClockFlag;
    logic [2:0] powerSpecRevisionField;
  } pm_cap_s;

  typedef enum logic [1:0] {
    STRAP_SYNC,
    STRAP_SETTLE,
    STRAP_HELD
  } strap_state_e;

endpackage : pm_cap_pkg

// ===== logic/pm_mode_sync.sv
// Purpose: Two-flop synchroniser for the mode-select strap pins.
// Assumes: Inputs are static straps or change rarely.
// Notes: Only the second stage may be read by other logic.
`timescale 1ns/10ps
`default_nettype none

module pm_mode_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // Asynchronous pins in, synchronised levels out
  input  wire logic [WIDTH-1:0] pinIn,
  output var  logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stageOne_reg;
  logic [WIDTH-1:0] stageTwo_reg;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      stageOne_reg <= '0;
      stageTwo_reg <= '0;
    end else begin
      stageOne_reg <= pinIn;
      stageTwo_reg <= stageOne_reg;
    end
  end

  assign syncOut = stageTwo_reg;

endmodule : pm_mode_sync

`default_nettype wire

// ===== logic/pm_capabilities_reg.sv
// Purpose: Read-only power-management capabilities word in configuration space.
// Assumes: Mode-select pins are straps, stable once reset has been released.
// Notes: Straps are captured once after release; reads return the captured view.
`timescale 1ns/10ps
`default_nettype none
`include "pm_cap_cfg.svh"

module pm_capabilities_reg
  import pm_cap_pkg::*;
#(
  parameter logic [2:0] AUX_CURRENT = `PMC_AUX_DEFAULT
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset,
  // Strap pins
  input  wire logic        modeSelectFirst,
  input  wire logic        modeSelectSecond,
  // Configuration access port
  input  wire logic        cfgReq,
  input  wire cfg_req_s    cfgReqInfo,
  input  wire logic [15:0] cfgWrData,
  output var  logic        cfgAck,
  output var  logic [15:0] cfgRdData,
  // Strap status
  output var  logic [3:0]  supportedStates,
  output var  logic        strapReady
);

  // Synchronised straps and their captured copies.
  logic [1:0]   modeSync;
  logic         modeFirst_reg;
  logic         modeFirst_next;
  logic         modeSecond_reg;
  logic         modeSecond_next;

  // Strap capture sequencer.
  strap_state_e strapState_reg;
  strap_state_e strapState_next;
  logic [1:0]   settleCount_reg;
  logic [1:0]   settleCount_next;
  logic         captureNow;

  // Access decode and answer.
  logic         readHit;
  logic         writeSeen;
  logic [15:0]  laneMask;
  logic [15:0]  readValue;
  pm_cap_s      capWord;
  logic         cfgAck_reg;
  logic [15:0]  cfgRdData_reg;
  logic [3:0]   states_reg;
  logic [3:0]   states_next;

  // The register answers on both bytes of its halfword, so address bit 0 is ignored.
  localparam logic [7:0] REG_OFFSET = `PMC_OFFSET;

  // Address match is used for read decode only; write decode ignores the address.
  function automatic logic addrHits(input logic [7:0] addr);
    addrHits = (addr[7:1] == REG_OFFSET[7:1]);
  endfunction : addrHits

  // Expands the two byte enables into a 16-bit lane mask.
  function automatic logic [15:0] laneExpand(input logic [1:0] byteEn);
    laneExpand = {{8{byteEn[1]}}, {8{byteEn[0]}}};
  endfunction : laneExpand

  pm_mode_sync #(
    .WIDTH (2)
  ) pm_mode_sync_inst (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pinIn   ({modeSelectSecond, modeSelectFirst}),
    .syncOut (modeSync)
  );

  // A fixed settle period lets the synchroniser flush reset zeros before capture.
  always_comb begin
    strapState_next  = strapState_reg;
    settleCount_next = settleCount_reg;
    captureNow       = 1'b0;
    case (strapState_reg)
      STRAP_SYNC: begin
        strapState_next  = STRAP_SETTLE;
        settleCount_next = `PMC_SETTLE_CYCLES;
      end
      STRAP_SETTLE: begin
        if (settleCount_reg == 2'h0) begin
          captureNow      = 1'b1;
          strapState_next = STRAP_HELD;
        end else begin
          settleCount_next = settleCount_reg - 2'h1;
        end
      end
      STRAP_HELD: begin
        strapState_next = STRAP_HELD;
      end
      default: begin
        strapState_next = STRAP_SYNC;
      end
    endcase
  end

  assign modeFirst_next  = captureNow ? modeSync[0] : modeFirst_reg;
  assign modeSecond_next = captureNow ? modeSync[1] : modeSecond_reg;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      strapState_reg  <= STRAP_SYNC;
      settleCount_reg <= 2'h0;
      modeFirst_reg   <= 1'b0;
      modeSecond_reg  <= 1'b0;
    end else begin
      strapState_reg  <= strapState_next;
      settleCount_reg <= settleCount_next;
      modeFirst_reg   <= modeFirst_next;
      modeSecond_reg  <= modeSecond_next;
    end
  end

  assign strapReady = (strapState_reg == STRAP_HELD);

  // Capability word assembled from constants and the captured straps only.
  assign capWord.wakeEventSupportField  = `PMC_WAKE_NONE;
  assign capWord.deeperStateSupportBit  = ~modeFirst_reg;
  assign capWord.lightStateSupportBit   = ~modeFirst_reg;
  assign capWord.auxCurrent             = AUX_CURRENT;
  assign capWord.specialInit            = 1'b0;
  assign capWord.reservedBit            = 1'b0;
  assign capWord.wakeEventClockFlag     = 1'b0;
  assign capWord.powerSpecRevisionField = modeFirst_reg ? `PMC_REV_1_0 : `PMC_REV_1_1;

  // The second strap switches the whole power-state set on or off.
  assign states_next = modeSecond_reg ? `PMC_STATES_NONE : `PMC_STATES_ALL;

  assign readHit   = cfgReq && !cfgReqInfo.write && addrHits(cfgReqInfo.addr);
  assign writeSeen = cfgReq && cfgReqInfo.write;
  assign laneMask  = laneExpand(cfgReqInfo.byteEn);
  // Writes and misses read back zero; write data is never stored anywhere.
  assign readValue = readHit ? (capWord & laneMask) : `PMC_READ_ZERO;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cfgAck_reg    <= 1'b0;
      cfgRdData_reg <= `PMC_READ_ZERO;
      states_reg    <= `PMC_STATES_ALL;
    end else begin
      cfgAck_reg    <= cfgReq;
      cfgRdData_reg <= readValue;
      states_reg    <= states_next;
    end
  end

  assign cfgAck          = cfgAck_reg;
  assign cfgRdData       = cfgRdData_reg;
  assign supportedStates = states_reg;

  // Checks on the power-state set, the answer path and strap readiness.

  a_all_states: assert property (
    @(posedge clk_sys) disable iff (reset)
    (strapReady && !modeSecond_reg) [*2] |-> supportedStates == `PMC_STATES_ALL
  ) else $error("power states not all supported with second strap low");

  a_no_states: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(modeSecond_reg) |=> supportedStates == `PMC_STATES_NONE
  ) else $error("power states still offered with second strap high");

  a_wake_zero: assert property (
    @(posedge clk_sys) disable iff (reset)
    readHit && cfgReqInfo.byteEn[1]
    |=> cfgAck && cfgRdData[`PMC_WAKE_MSB:`PMC_WAKE_LSB] == `PMC_WAKE_NONE
  ) else $error("wake-event support field not zero");

  a_deeper_bit: assert property (
    @(posedge clk_sys) disable iff (reset)
    readHit && cfgReqInfo.byteEn[1]
    |=> cfgRdData[`PMC_DEEPER_BIT] == !$past(modeFirst_reg)
  ) else $error("deeper state bit does not follow first strap");

  a_light_bit: assert property (
    @(posedge clk_sys) disable iff (reset)
    readHit && cfgReqInfo.byteEn[1]
    |=> cfgRdData[`PMC_LIGHT_BIT] != $past(modeFirst_reg)
  ) else $error("light state bit does not follow first strap");

  a_aux_field: assert property (
    @(posedge clk_sys) disable iff (reset)
    readHit && cfgReqInfo.byteEn == `PMC_BYTES_ALL
    |=> cfgRdData[`PMC_AUX_MSB:`PMC_AUX_LSB] == AUX_CURRENT
  ) else $error("auxiliary current field wrong");

  a_init_zero: assert property (
    @(posedge clk_sys) disable iff (reset)
    cfgAck |-> !cfgRdData[`PMC_INIT_BIT]
  ) else $error("special initialization flag set");

  a_rsvd_zero: assert property (
    @(posedge clk_sys) disable iff (reset)
    cfgAck |-> !cfgRdData[`PMC_RSVD_BIT]
  ) else $error("reserved bit set");

  a_wclk_zero: assert property (
    @(posedge clk_sys) disable iff (reset)
    cfgAck |-> cfgRdData[`PMC_WCLK_BIT] == 1'b0
  ) else $error("wake-event clock flag set");

  a_rev_old: assert property (
    @(posedge clk_sys) disable iff (reset)
    readHit && cfgReqInfo.byteEn[0] && modeFirst_reg
    |=> cfgRdData[`PMC_REV_MSB:`PMC_REV_LSB] == `PMC_REV_1_0
  ) else $error("revision not 1.0 with first strap high");

  a_rev_new: assert property (
    @(posedge clk_sys) disable iff (reset)
    readHit && cfgReqInfo.byteEn[0] && !modeFirst_reg
    |=> cfgRdData[`PMC_REV_MSB:`PMC_REV_LSB] == `PMC_REV_1_1
  ) else $error("revision not 1.1 with first strap low");

  // A write may share its edge with the strap capture, and only then may the straps move.
  a_write_ignored: assert property (
    @(posedge clk_sys) disable iff (reset)
    writeSeen |=> cfgAck && cfgRdData == `PMC_READ_ZERO
      && ($past(captureNow) || ($stable(modeFirst_reg) && $stable(modeSecond_reg)))
  ) else $error("configuration write had an effect");

  a_ack_once: assert property (
    @(posedge clk_sys) disable iff (reset)
    cfgReq |=> cfgAck ##1 (cfgAck == $past(cfgReq))
  ) else $error("acknowledge not one cycle after request");

  a_strap_ready: assert property (
    @(posedge clk_sys) disable iff (reset)
    $rose(strapReady) |-> $past(strapState_reg) == STRAP_SETTLE ##1 strapReady [*3]
  ) else $error("strap capture did not hold");

  // Checks on access decode, read data, the power-state set and the strap capture sequence.

  a_miss_zero: assert property (
    @(posedge clk_sys) disable iff (reset)
    cfgReq && !readHit |=> cfgRdData == `PMC_READ_ZERO
  ) else $error("miss or write returned nonzero data");

  a_idle_quiet: assert property (
    @(posedge clk_sys) disable iff (reset)
    !cfgReq |=> !cfgAck && cfgRdData == `PMC_READ_ZERO
  ) else $error("answer without a request");

  a_low_lane_off: assert property (
    @(posedge clk_sys) disable iff (reset)
    cfgReq && !cfgReqInfo.byteEn[0] |=> cfgRdData[7:0] == 8'h00
  ) else $error("disabled low lane returned data");

  a_high_lane_off: assert property (
    @(posedge clk_sys) disable iff (reset)
    cfgReq && !cfgReqInfo.byteEn[1] |=> cfgRdData[15:8] == 8'h00
  ) else $error("disabled high lane returned data");

  a_pair_match: assert property (
    @(posedge clk_sys) disable iff (reset)
    readHit && cfgReqInfo.byteEn[1] |=> cfgRdData[`PMC_DEEPER_BIT] == cfgRdData[`PMC_LIGHT_BIT]
  ) else $error("deeper and light state bits disagree");

  a_rev_legal: assert property (
    @(posedge clk_sys) disable iff (reset)
    readHit && cfgReqInfo.byteEn[0]
    |=> cfgRdData[`PMC_REV_MSB:`PMC_REV_LSB] == `PMC_REV_1_0
      || cfgRdData[`PMC_REV_MSB:`PMC_REV_LSB] == `PMC_REV_1_1
  ) else $error("revision field holds an unknown code");

  a_straps_frozen: assert property (
    @(posedge clk_sys) disable iff (reset)
    strapReady |=> $stable(modeFirst_reg) && $stable(modeSecond_reg)
  ) else $error("captured straps moved after capture");

  a_states_stable: assert property (
    @(posedge clk_sys) disable iff (reset)
    $past(strapReady, 2) && strapReady |-> $stable(supportedStates)
  ) else $error("power state set moved after capture");

  a_states_legal: assert property (
    @(posedge clk_sys) disable iff (reset)
    supportedStates == `PMC_STATES_ALL || supportedStates == `PMC_STATES_NONE
  ) else $error("power state set is neither all nor none");

  a_ready_stays: assert property (
    @(posedge clk_sys) disable iff (reset)
    strapReady |=> strapReady
  ) else $error("strap ready dropped without reset");

  a_capture_once: assert property (
    @(posedge clk_sys) disable iff (reset)
    captureNow |=> strapReady && !captureNow
  ) else $error("strap capture repeated");

  a_sync_not_ready: assert property (
    @(posedge clk_sys) disable iff (reset)
    strapState_reg == STRAP_SYNC |=> !strapReady
  ) else $error("strap ready before settle period");

  a_count_range: assert property (
    @(posedge clk_sys) disable iff (reset)
    strapState_reg == STRAP_SETTLE |-> settleCount_reg <= `PMC_SETTLE_CYCLES
  ) else $error("settle counter out of range");

endmodule : pm_capabilities_reg

`default_nettype wire

// ===== bench/pm_capabilities_reg_tb.sv
// Purpose: Self-checking bench for the power-management capabilities register.
// Assumes: Straps are set before each reset and held through release.
// Notes: Each strap setting needs its own reset, because straps are captured only once.
`timescale 1ns/10ps
`default_nettype none

module pm_capabilities_reg_tb;
  import pm_cap_pkg::*;

  typedef struct packed {
    logic        write;
    logic [7:0]  addr;
    logic [1:0]  byteEn;
    logic [15:0] mask;
  } row_s;

  localparam logic [2:0] AUX = 3'h5;

  logic        clk_sys = 1'b0;
  logic        reset = 1'b1;
  logic        modeSelectFirst = 1'b0;
  logic        modeSelectSecond = 1'b0;
  logic        cfgReq = 1'b0;
  cfg_req_s    cfgReqInfo = '0;
  logic [15:0] cfgWrData = 16'h0000;
  logic        cfgAck;
  logic [15:0] cfgRdData;
  logic [3:0]  supportedStates;
  logic        strapReady;
  int          mismatches = 0;
  int          cmpCount = 0;
  row_s        rows [8];

  always #4 clk_sys = ~clk_sys;

  pm_capabilities_reg #(.AUX_CURRENT(AUX)) pm_capabilities_reg_inst (
    .clk_sys          (clk_sys),
    .reset            (reset),
    .modeSelectFirst  (modeSelectFirst),
    .modeSelectSecond (modeSelectSecond),
    .cfgReq           (cfgReq),
    .cfgReqInfo       (cfgReqInfo),
    .cfgWrData        (cfgWrData),
    .cfgAck           (cfgAck),
    .cfgRdData        (cfgRdData),
    .supportedStates  (supportedStates),
    .strapReady       (strapReady)
  );

  function automatic logic [15:0] expWord(input logic f);
    return {5'h00, ~f, ~f, AUX, 3'h0, (f ? 3'h1 : 3'h2)};
  endfunction : expWord

  task automatic cmpWord(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmpCount++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask : cmpWord

  task automatic cmpFlag(input string what, input logic exp, input logic got);
    cmpCount++;
    if (got !== exp) begin
      $display("mismatch %s expected %b seen %b", what, exp, got);
      mismatches++;
    end
  endtask : cmpFlag

  task automatic endSim();
    $display("comparisons %0d mismatches %0d", cmpCount, mismatches);
    if (mismatches == 0 && cmpCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : endSim

  // One access: ack and data are looked at in the single cycle that they stand.
  task automatic access(input row_s r, input logic [15:0] exp);
    @(negedge clk_sys);
    cfgReq = 1'b1;
    cfgReqInfo = {r.write, r.addr, r.byteEn};
    cfgWrData = r.write ? 16'hffff : 16'h0000;
    @(posedge clk_sys);
    @(negedge clk_sys);
    cfgReq = 1'b0;
    cmpFlag("cfgAck", 1'b1, cfgAck);
    cmpWord("cfgRdData", exp, cfgRdData);
    @(posedge clk_sys);
    @(negedge clk_sys);
    cmpFlag("cfgAck low", 1'b0, cfgAck);
  endtask : access

  task automatic doReset(input logic f, input logic s);
    @(negedge clk_sys);
    reset = 1'b1;
    modeSelectFirst = f;
    modeSelectSecond = s;
    repeat (12) @(negedge clk_sys);
    cmpFlag("reset cfgAck", 1'b0, cfgAck);
    cmpWord("reset cfgRdData", 16'h0000, cfgRdData);
    cmpWord("reset states", 16'h000f, {12'h000, supportedStates});
    cmpFlag("reset strapReady", 1'b0, strapReady);
    reset = 1'b0;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    cmpFlag("strapReady early", 1'b0, strapReady);
    @(posedge clk_sys);
    @(negedge clk_sys);
    cmpFlag("strapReady", 1'b1, strapReady);
    @(negedge clk_sys);
    cmpWord("states", s ? 16'h0000 : 16'h000f, {12'h000, supportedStates});
  endtask : doReset

  initial begin
    #50000;
    mismatches++;
    endSim();
  end

  initial begin
    logic [15:0] w;
    rows[0] = '{1'b0, 8'hde, 2'h3, 16'hffff};
    rows[1] = '{1'b0, 8'hdf, 2'h3, 16'hffff};
    rows[2] = '{1'b0, 8'hde, 2'h1, 16'h00ff};
    rows[3] = '{1'b1, 8'hde, 2'h3, 16'h0000};
    rows[4] = '{1'b0, 8'hde, 2'h2, 16'hff00};
    rows[5] = '{1'b0, 8'hde, 2'h0, 16'h0000};
    rows[6] = '{1'b0, 8'hdc, 2'h3, 16'h0000};
    rows[7] = '{1'b0, 8'he0, 2'h3, 16'h0000};
    for (int c = 0; c < 4; c++) begin
      doReset(c[0], c[1]);
      w = expWord(c[0]);
      for (int i = 0; i < 8; i++) begin
        access(rows[i], w & rows[i].mask);
      end
      // Back-to-back reads with a write squeezed between them.
      @(negedge clk_sys);
      cfgReq = 1'b1;
      cfgReqInfo = {1'b0, 8'hde, 2'h3};
      @(negedge clk_sys);
      cmpWord("b2b first", w, cfgRdData);
      cfgReqInfo = {1'b1, 8'hde, 2'h3};
      cfgWrData = ~w;
      @(negedge clk_sys);
      cmpWord("b2b write", 16'h0000, cfgRdData);
      cfgReqInfo = {1'b0, 8'hdf, 2'h3};
      @(negedge clk_sys);
      cmpWord("b2b last", w, cfgRdData);
      cmpFlag("b2b ack", 1'b1, cfgAck);
      cfgReq = 1'b0;
      // Pins moving after capture must not disturb the captured view.
      modeSelectFirst = ~c[0];
      modeSelectSecond = ~c[1];
      repeat (6) @(negedge clk_sys);
      access(rows[0], w);
      cmpWord("states held", c[1] ? 16'h0000 : 16'h000f, {12'h000, supportedStates});
    end
    endSim();
  end

endmodule : pm_capabilities_reg_tb

`default_nettype wire
